// [include/dma_cfg.svh]
// Register map, field positions, reset values and timing of the DMA block
`ifndef DMA_CFG_SVH
`define DMA_CFG_SVH

// Register byte offsets on the bus
`define REG_ARM 8'h00
`define REG_REQ 8'h04
`define REG_DONE 8'h08
`define REG_IRQF 8'h0C
`define REG_IEN 8'h10
`define REG_CFG0 8'h14
`define REG_CFG1 8'h18

// Field positions
`define ARM_ABORT_BIT 7
`define CFG_STRIDE_SHIFT 3

// Reset values
`define EVENT_SELECTOR_RST 5'h00
`define BASE_RST 16'h0000

// Timing and sizes
`define LOAD_CYC 9
`define CFG_BYTES 8
`define CNT_W 14
`define WORD_N_BITS 13

// Count source codes
`define COUNT_SOURCE_SELECTOR_N1 3'h1
`define COUNT_SOURCE_SELECTOR_N 3'h2
`define COUNT_SOURCE_SELECTOR_N2 3'h3
`define COUNT_SOURCE_SELECTOR_N3 3'h4

`endif

// [include/dma_pkg.sv]
// Types shared by the DMA mover and its configuration loader
package dma_pkg;

  typedef enum logic [1:0] {TM_SINGLE, TM_BLOCK, TM_RSINGLE, TM_RBLOCK}
    transfer_mode_selector_e;

  typedef enum logic [1:0] {INC_0, INC_1, INC_2, DEC_1} inc_e;

  typedef enum logic [1:0] {ENG_IDLE, ENG_RD, ENG_WR} eng_e;

  // Eight-byte configuration, first byte in the top bits
  typedef struct packed {
    logic [15:0] src;
    logic [15:0] dst;
    logic [2:0] count_source_selector;
    logic [12:0] len;
    logic word;
    transfer_mode_selector_e transfer_mode_selector;
    logic [4:0] event_selector;
    inc_e sinc;
    inc_e dinc;
    logic completion_irq_permit;
    logic m8;
    logic [1:0] prio;
  } chan_cfg_s;

  // One request on the external-data memory port
  typedef struct packed {
    logic req;
    logic we;
    logic word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_req_s;

endpackage

// [design/cfg_loader.sv]
// Configuration fetcher: nine cycles per channel, channel 0 last
`timescale 1ns/1ns
`include "dma_cfg.svh"
module cfg_loader #(
  parameter int N_CH = 5
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Load requests and hold-off
  input wire logic [N_CH-1:0] i_load,
  input wire logic i_hold,
  input wire logic [15:0] i_base0,
  input wire logic [15:0] i_base1,
  // Memory port
  output dma_pkg::mem_req_s o_mem,
  input wire logic i_mem_ack,
  input wire logic [15:0] i_mem_rdata,
  // Result
  output logic o_busy,
  output logic o_commit,
  output logic [2:0] o_ch,
  output dma_pkg::chan_cfg_s o_cfg
);
  import dma_pkg::*;

  if (N_CH < 2 || N_CH > 8) begin : g_bad_n_ch
    $error("cfg_loader: N_CH must be 2 to 8");
  end

  logic [N_CH-1:0] pend_ff, nxt_pend;
  logic busy_ff, nxt_busy;
  logic [2:0] ch_ff, nxt_ch;
  logic [3:0] step_ff, nxt_step;
  logic [63:0] buf_ff, nxt_buf;
  logic start;
  logic free;

  // Channels 1 upward first, channel 0 only when no other waits
  function automatic logic [2:0] pick(input logic [N_CH-1:0] m);
    logic [2:0] p;
    p = 3'h0;
    for (int i = N_CH - 1; i >= 1; i--) begin
      if (m[i]) begin
        p = 3'(i);
      end
    end
    return p;
  endfunction

  // Next-state of the fetch sequencer
  always_comb begin
    nxt_pend = pend_ff | i_load;
    nxt_busy = busy_ff;
    nxt_ch = ch_ff;
    nxt_step = step_ff;
    nxt_buf = buf_ff;
    o_commit = busy_ff && step_ff == 4'(`LOAD_CYC - 1);
    free = !busy_ff || o_commit;
    start = free && (|nxt_pend) && !i_hold;
    if (busy_ff && !o_commit && i_mem_ack) begin
      nxt_buf[(`CFG_BYTES - 1 - int'(step_ff)) * 8 +: 8] = i_mem_rdata[7:0];
      nxt_step = step_ff + 4'h1;
    end
    if (o_commit) begin
      nxt_busy = 1'b0;
    end
    if (start) begin
      nxt_busy = 1'b1;
      nxt_ch = pick(nxt_pend);
      nxt_step = 4'h0;
      nxt_pend[nxt_ch] = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pend_ff <= '0;
      busy_ff <= 1'b0;
      ch_ff <= 3'h0;
      step_ff <= 4'h0;
      buf_ff <= 64'h0;
    end else begin
      pend_ff <= nxt_pend;
      busy_ff <= nxt_busy;
      ch_ff <= nxt_ch;
      step_ff <= nxt_step;
      buf_ff <= nxt_buf;
    end
  end

  // Channel 0 has its own base; 1 upward share a packed area
  always_comb begin
    o_mem = '0;
    o_mem.req = busy_ff && !o_commit;
    o_mem.addr = (ch_ff == 3'h0 ? i_base0 :
      i_base1 + 16'({ch_ff - 3'h1, 3'h0})) + 16'(step_ff);
  end

  assign o_busy = busy_ff || start;
  assign o_ch = ch_ff;
  assign o_cfg = chan_cfg_s'(buf_ff);

  sequence s_fetch;
    i_mem_ack [*8];
  endsequence

  a_load_nine: assert property (@(posedge i_clk) disable iff (!i_resetn)
    start ##1 s_fetch |=> o_commit)
    else $error("config load did not finish in nine cycles");

  a_load_order: assert property (@(posedge i_clk) disable iff (!i_resetn)
    start && nxt_ch == 3'h0 |-> !(|pend_ff[N_CH-1:1]))
    else $error("channel 0 loaded before another channel");
endmodule

// [design/dma_mover.sv]
// Five-channel memory mover with Avalon-MM register slave
`timescale 1ns/1ns
`include "dma_cfg.svh"
module dma_mover #(
  parameter int N_CH = 5,
  parameter int N_EVENT_SELECTOR = 30
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Register bus
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // External-data memory port
  output dma_pkg::mem_req_s o_mem,
  input wire logic i_mem_ack,
  input wire logic [15:0] i_mem_rdata,
  // Trigger events
  input wire logic [N_EVENT_SELECTOR-1:0] i_event_selector,
  // Cpu interrupt request
  output logic o_irq
);
  import dma_pkg::*;

  if (N_CH != 5 || N_EVENT_SELECTOR < 2 || N_EVENT_SELECTOR > 32) begin : g_bad_param
    $error("dma_mover: needs N_CH 5 and N_EVENT_SELECTOR 2 to 32");
  end

  // Bus state
  logic served_ff, nxt_served;
  logic [31:0] rdata_ff, nxt_rdata;
  logic ien_ff, nxt_ien;
  logic [15:0] base0_ff, nxt_base0;
  logic [15:0] base1_ff, nxt_base1;
  logic wr;
  logic [N_CH-1:0] arm_set, abort_clr, man_req, done_w1c;
  logic irqf_w1c;

  // Channel and engine state
  chan_cfg_s cfg_ff [N_CH];
  chan_cfg_s nxt_cfg [N_CH];
  logic [4:0] event_selector_ff [N_CH];
  logic [4:0] nxt_event_selector [N_CH];
  logic [15:0] sptr_ff [N_CH];
  logic [15:0] nxt_sptr [N_CH];
  logic [15:0] dptr_ff [N_CH];
  logic [15:0] nxt_dptr [N_CH];
  logic [`CNT_W-1:0] cnt_ff [N_CH];
  logic [`CNT_W-1:0] nxt_cnt [N_CH];
  logic [`CNT_W-1:0] tgt_ff [N_CH];
  logic [`CNT_W-1:0] nxt_tgt [N_CH];
  logic [N_CH-1:0] armed_ff, nxt_armed;
  logic [N_CH-1:0] pend_ff, nxt_pend;
  logic [N_CH-1:0] first_ff, nxt_first;
  logic [N_CH-1:0] done_ff, nxt_done;
  logic irqf_ff, nxt_irqf;
  eng_e eng_ff, nxt_eng;
  logic [2:0] cur_ff, nxt_cur;
  logic [2:0] rr_ff, nxt_rr;
  logic [15:0] data_ff, nxt_data;
  logic [N_CH-1:0] hit, done_set, pend_clr;
  logic [2*N_CH-1:0] prio_vec;
  logic done_ev;
  logic last_one;
  logic cap_hit;
  logic [31:0] trig32;
  chan_cfg_s cc;
  mem_req_s eng_mem, ld_mem;
  logic ld_busy, ld_commit;
  logic [2:0] ld_ch;
  chan_cfg_s ld_cfg;

  // Pointer step between elementary transfers
  function automatic logic [15:0] step(input logic [15:0] p,
                                       input inc_e inc);
    logic [15:0] r;
    r = p;
    unique case (inc)
      INC_0: r = p;
      INC_1: r = p + 16'h0001;
      INC_2: r = p + 16'h0002;
      DEC_1: r = p - 16'h0001;
    endcase
    return r;
  endfunction

  // First-item count n: 13 word bits, or 7 or 8 bits of a byte
  function automatic logic [`CNT_W-1:0] n_of(input chan_cfg_s c,
                                              input logic [15:0] d);
    logic [`CNT_W-1:0] n;
    if (c.word) begin
      n = `CNT_W'(d[`WORD_N_BITS-1:0]);
    end else if (c.m8) begin
      n = `CNT_W'(d[6:0]);
    end else begin
      n = `CNT_W'(d[7:0]);
    end
    return n;
  endfunction

  // Transfer count from the count source selector and first item
  function automatic logic [`CNT_W-1:0] count_of(input chan_cfg_s c,
                                                  input logic [15:0] d);
    logic [`CNT_W-1:0] n;
    logic [`CNT_W-1:0] lim;
    logic [`CNT_W-1:0] v;
    lim = `CNT_W'(c.len);
    n = n_of(c, d);
    case (c.count_source_selector)
      `COUNT_SOURCE_SELECTOR_N1: v = n + `CNT_W'(1);
      `COUNT_SOURCE_SELECTOR_N: v = n;
      `COUNT_SOURCE_SELECTOR_N2: v = n + `CNT_W'(2);
      `COUNT_SOURCE_SELECTOR_N3: v = n + `CNT_W'(3);
      default: v = lim;
    endcase
    if (n >= lim) begin
      v = lim;
    end
    return v;
  endfunction

  // Highest priority wins, ties go to the next after the last winner
  function automatic logic [2:0] arb(input logic [N_CH-1:0] rdy,
                                     input logic [2*N_CH-1:0] pr,
                                     input logic [2:0] rr);
    logic [2:0] win;
    logic [2:0] idx;
    logic [1:0] best;
    logic found;
    win = 3'h0;
    best = 2'h0;
    found = 1'b0;
    for (int k = 1; k <= N_CH; k++) begin
      idx = 3'((int'(rr) + k) % N_CH);
      if (rdy[idx] && (!found || pr[2*idx +: 2] > best)) begin
        win = idx;
        best = pr[2*idx +: 2];
        found = 1'b1;
      end
    end
    return win;
  endfunction

  // Bus strobes: a write lands at the edge that samples waitrequest low
  always_comb begin
    wr = i_avs_write && served_ff && i_avs_byteenable[0];
    arm_set = '0;
    abort_clr = '0;
    man_req = '0;
    done_w1c = '0;
    irqf_w1c = 1'b0;
    if (wr && i_avs_address == `REG_ARM) begin
      if (i_avs_writedata[`ARM_ABORT_BIT]) begin
        abort_clr = i_avs_writedata[N_CH-1:0];
      end else begin
        arm_set = i_avs_writedata[N_CH-1:0];
      end
    end
    if (wr && i_avs_address == `REG_REQ) begin
      man_req = i_avs_writedata[N_CH-1:0];
    end
    if (wr && i_avs_address == `REG_DONE) begin
      done_w1c = i_avs_writedata[N_CH-1:0];
    end
    if (wr && i_avs_address == `REG_IRQF) begin
      irqf_w1c = i_avs_writedata[0];
    end
  end

  // Bus registers, one wait cycle per access, read data from a flop
  always_comb begin
    nxt_served = (i_avs_read || i_avs_write) && !served_ff;
    nxt_rdata = rdata_ff;
    nxt_ien = ien_ff;
    nxt_base0 = base0_ff;
    nxt_base1 = base1_ff;
    if (i_avs_read && !served_ff) begin
      case (i_avs_address)
        `REG_ARM: nxt_rdata = 32'(armed_ff);
        `REG_REQ: nxt_rdata = 32'(pend_ff);
        `REG_DONE: nxt_rdata = 32'(done_ff);
        `REG_IRQF: nxt_rdata = 32'(irqf_ff);
        `REG_IEN: nxt_rdata = 32'(ien_ff);
        `REG_CFG0: nxt_rdata = 32'(base0_ff);
        `REG_CFG1: nxt_rdata = 32'(base1_ff);
        default: nxt_rdata = 32'h00000000;
      endcase
    end
    if (wr && i_avs_address == `REG_IEN) begin
      nxt_ien = i_avs_writedata[0];
    end
    if (i_avs_write && served_ff && i_avs_address == `REG_CFG0) begin
      if (i_avs_byteenable[0]) nxt_base0[7:0] = i_avs_writedata[7:0];
      if (i_avs_byteenable[1]) nxt_base0[15:8] = i_avs_writedata[15:8];
    end
    if (i_avs_write && served_ff && i_avs_address == `REG_CFG1) begin
      if (i_avs_byteenable[0]) nxt_base1[7:0] = i_avs_writedata[7:0];
      if (i_avs_byteenable[1]) nxt_base1[15:8] = i_avs_writedata[15:8];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      served_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      ien_ff <= 1'b0;
      base0_ff <= `BASE_RST;
      base1_ff <= `BASE_RST;
    end else begin
      served_ff <= nxt_served;
      rdata_ff <= nxt_rdata;
      ien_ff <= nxt_ien;
      base0_ff <= nxt_base0;
      base1_ff <= nxt_base1;
    end
  end

  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !served_ff;
  assign o_avs_readdata = rdata_ff;
  assign o_irq = irqf_ff && ien_ff;

  // Configuration fetch, given the memory port ahead of the engine
  cfg_loader #(
    .N_CH(N_CH)
  ) u_loader (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_load(arm_set),
    .i_hold(eng_ff != ENG_IDLE),
    .i_base0(base0_ff),
    .i_base1(base1_ff),
    .o_mem(ld_mem),
    .i_mem_ack(i_mem_ack),
    .i_mem_rdata(i_mem_rdata),
    .o_busy(ld_busy),
    .o_commit(ld_commit),
    .o_ch(ld_ch),
    .o_cfg(ld_cfg)
  );

  // Trigger vector; event 0 means manual request only
  assign trig32 = 32'(i_event_selector) & 32'hFFFFFFFE;

  // Channels and transfer engine
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_event_selector = event_selector_ff;
    nxt_sptr = sptr_ff;
    nxt_dptr = dptr_ff;
    nxt_cnt = cnt_ff;
    nxt_tgt = tgt_ff;
    nxt_first = first_ff;
    nxt_eng = eng_ff;
    nxt_cur = cur_ff;
    nxt_rr = rr_ff;
    nxt_data = data_ff;
    nxt_irqf = irqf_ff && !irqf_w1c;
    done_set = '0;
    pend_clr = abort_clr;
    done_ev = 1'b0;
    last_one = 1'b0;
    nxt_armed = (armed_ff | arm_set) & ~abort_clr;
    cc = cfg_ff[cur_ff];
    // First item at or above the limit caps the count
    cap_hit = n_of(cc, i_mem_rdata) >= `CNT_W'(cc.len);
    eng_mem = '0;
    eng_mem.word = cc.word;
    for (int c = 0; c < N_CH; c++) begin
      prio_vec[2*c +: 2] = cfg_ff[c].prio;
      // Old trigger stays in force until the new setup lands
      hit[c] = man_req[c] || trig32[event_selector_ff[c]];
    end
    // New configuration lands; pointers restart at the start addresses
    if (ld_commit) begin
      nxt_cfg[ld_ch] = ld_cfg;
      nxt_event_selector[ld_ch] = ld_cfg.event_selector;
      nxt_sptr[ld_ch] = ld_cfg.src;
      nxt_dptr[ld_ch] = ld_cfg.dst;
      nxt_cnt[ld_ch] = '0;
      nxt_tgt[ld_ch] = `CNT_W'(ld_cfg.len);
      nxt_first[ld_ch] = 1'b1;
    end
    unique case (eng_ff)
      ENG_IDLE: begin
        if (!ld_busy && |(armed_ff & pend_ff)) begin
          nxt_cur = arb(armed_ff & pend_ff, prio_vec, rr_ff);
          nxt_rr = nxt_cur;
          pend_clr[nxt_cur] = 1'b1;
          nxt_eng = ENG_RD;
        end
      end
      ENG_RD: begin
        eng_mem.req = 1'b1;
        eng_mem.addr = sptr_ff[cur_ff];
        if (i_mem_ack) begin
          nxt_data = cc.word ? i_mem_rdata : {8'h00, i_mem_rdata[7:0]};
          if (first_ff[cur_ff]) begin
            nxt_tgt[cur_ff] = count_of(cc, i_mem_rdata);
            nxt_first[cur_ff] = 1'b0;
          end
          nxt_eng = ENG_WR;
        end
      end
      ENG_WR: begin
        eng_mem.req = 1'b1;
        eng_mem.we = 1'b1;
        eng_mem.addr = dptr_ff[cur_ff];
        eng_mem.wdata = data_ff;
        if (i_mem_ack) begin
          nxt_sptr[cur_ff] = step(sptr_ff[cur_ff], cc.sinc);
          nxt_dptr[cur_ff] = step(dptr_ff[cur_ff], cc.dinc);
          nxt_cnt[cur_ff] = cnt_ff[cur_ff] + `CNT_W'(1);
          last_one = nxt_cnt[cur_ff] >= tgt_ff[cur_ff];
          nxt_eng = ENG_IDLE;
          if (last_one) begin
            done_ev = 1'b1;
            done_set[cur_ff] = 1'b1;
            if (cc.completion_irq_permit) nxt_irqf = 1'b1;
            if (cc.transfer_mode_selector == TM_SINGLE || cc.transfer_mode_selector == TM_BLOCK) begin
              nxt_armed[cur_ff] = 1'b0;
            end else begin
              nxt_sptr[cur_ff] = cc.src;
              nxt_dptr[cur_ff] = cc.dst;
              nxt_cnt[cur_ff] = '0;
              nxt_tgt[cur_ff] = `CNT_W'(cc.len);
              nxt_first[cur_ff] = 1'b1;
            end
          end else if (cc.transfer_mode_selector == TM_BLOCK || cc.transfer_mode_selector == TM_RBLOCK) begin
            nxt_eng = ENG_RD;
          end
        end
      end
      default: nxt_eng = ENG_IDLE;
    endcase
    // Hardware sets win over clears in the same cycle, except that an abort clears a pending set
    nxt_pend = (pend_ff & ~pend_clr) | (hit & nxt_armed);
    nxt_done = (done_ff & ~done_w1c) | done_set;
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      for (int c = 0; c < N_CH; c++) begin
        cfg_ff[c] <= '0;
        event_selector_ff[c] <= `EVENT_SELECTOR_RST;
        sptr_ff[c] <= 16'h0000;
        dptr_ff[c] <= 16'h0000;
        cnt_ff[c] <= '0;
        tgt_ff[c] <= '0;
      end
      armed_ff <= '0;
      pend_ff <= '0;
      first_ff <= '1;
      done_ff <= '0;
      irqf_ff <= 1'b0;
      eng_ff <= ENG_IDLE;
      cur_ff <= 3'h0;
      rr_ff <= 3'h0;
      data_ff <= 16'h0000;
    end else begin
      cfg_ff <= nxt_cfg;
      event_selector_ff <= nxt_event_selector;
      sptr_ff <= nxt_sptr;
      dptr_ff <= nxt_dptr;
      cnt_ff <= nxt_cnt;
      tgt_ff <= nxt_tgt;
      armed_ff <= nxt_armed;
      pend_ff <= nxt_pend;
      first_ff <= nxt_first;
      done_ff <= nxt_done;
      irqf_ff <= nxt_irqf;
      eng_ff <= nxt_eng;
      cur_ff <= nxt_cur;
      rr_ff <= nxt_rr;
      data_ff <= nxt_data;
    end
  end

  // Loader owns the port while it fetches
  assign o_mem = ld_mem.req ? ld_mem : eng_mem;

  sequence s_rd_wr;
    eng_ff == ENG_RD && i_mem_ack ##1 eng_ff == ENG_WR;
  endsequence

  a_start_armed: assert property (@(posedge i_clk) disable iff (!i_resetn)
    eng_ff == ENG_IDLE && nxt_eng == ENG_RD |-> armed_ff[nxt_cur])
    else $error("transfer started on an unarmed channel");

  a_done_flag: assert property (@(posedge i_clk) disable iff (!i_resetn)
    done_ev |=> done_ff[$past(cur_ff)])
    else $error("done bit not set at count");

  a_irq_flag: assert property (@(posedge i_clk) disable iff (!i_resetn)
    done_ev && cc.completion_irq_permit |=> irqf_ff ##0 (o_irq == ien_ff))
    else $error("cpu flag or request wrong at count");

  a_single_off: assert property (@(posedge i_clk) disable iff (!i_resetn)
    done_ev && !cc.transfer_mode_selector[1] |=> !armed_ff[$past(cur_ff)])
    else $error("single or block channel still armed");

  a_repeat_on: assert property (@(posedge i_clk) disable iff (!i_resetn)
    done_ev && cc.transfer_mode_selector[1] && !(|abort_clr)
    |=> armed_ff[$past(cur_ff)])
    else $error("repeated channel not rearmed");

  a_block_chain: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_rd_wr ##0 i_mem_ack && !last_one && cc.transfer_mode_selector[0]
    |=> eng_ff == ENG_RD)
    else $error("block transfer not back to back");

  a_single_step: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_rd_wr ##0 i_mem_ack && !cc.transfer_mode_selector[0] |=> eng_ff == ENG_IDLE)
    else $error("single mode moved more than one item");

  a_count_cap: assert property (@(posedge i_clk) disable iff (!i_resetn)
    eng_ff == ENG_RD && i_mem_ack && first_ff[cur_ff] && cap_hit
    |=> tgt_ff[$past(cur_ff)] == `CNT_W'(cc.len))
    else $error("transfer count above the limit");

  a_width_sel: assert property (@(posedge i_clk) disable iff (!i_resetn)
    eng_ff == ENG_WR && !cc.word |-> o_mem.wdata[15:8] == 8'h00)
    else $error("byte transfer carried upper bits");
endmodule

// [sim/external_data_space_mem.sv]
// External-data memory model answering the mover's memory port
`timescale 1ns/1ns
module external_data_space_mem (
  // Clock
  input wire logic i_clk,
  // Request side
  input wire dma_pkg::mem_req_s i_mem,
  input wire logic i_slow,
  // Answer side
  output logic o_ack,
  output logic [15:0] o_rdata
);
  import dma_pkg::*;
  logic [7:0] mem [0:1023];
  logic [15:0] last_ff = 16'h0000;
  logic tog_ff = 1'b0;
  logic [9:0] a;

  // Every location is writable space, so no write is refused
  assign a = i_mem.addr[9:0];
  // Slow mode answers only every other cycle
  assign o_ack = i_mem.req && (!i_slow || tog_ff);

  // Big-endian words; an idle bus shows the inverse of the last value
  always_comb begin
    if (o_ack && !i_mem.we) begin
      o_rdata = i_mem.word ? {mem[a], mem[a+10'h1]} : {8'h00, mem[a]};
    end else begin
      o_rdata = ~last_ff;
    end
  end

  // Writes land at the acknowledging edge
  always_ff @(posedge i_clk) begin
    tog_ff <= ~tog_ff;
    if (o_ack) begin
      last_ff <= o_rdata;
      if (i_mem.we && i_mem.word) begin
        mem[a] <= i_mem.wdata[15:8];
        mem[a+10'h1] <= i_mem.wdata[7:0];
      end else if (i_mem.we) begin
        mem[a] <= i_mem.wdata[7:0];
      end
    end
  end
endmodule

// [sim/tb_dma_mover.sv]
// Self-checking bench for the five-channel mover
`timescale 1ns/1ns
module tb_dma_mover;
  import dma_pkg::*;
  logic i_clk, i_resetn, rd, wr, wreq, ack, slow, irq;
  logic [7:0] adr;
  logic [3:0] be;
  logic [31:0] wd, rdat, q;
  logic [15:0] mrd;
  logic [29:0] event_selector;
  mem_req_s mreq;
  chan_cfg_s c;
  int failures, checks, seed, k, n;
  logic [7:0] k_list [5] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'hFC};

  dma_mover u_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(be), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .o_mem(mreq), .i_mem_ack(ack),
    .i_mem_rdata(mrd), .i_event_selector(event_selector), .o_irq(irq));
  external_data_space_mem u_mem (.i_clk(i_clk), .i_mem(mreq), .i_slow(slow),
    .o_ack(ack), .o_rdata(mrd));

  // Clock
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic final_report();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One Avalon cycle; read data lands in q
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int t;
    t = 0;
    @(posedge i_clk);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    // Hold the request until waitrequest is seen low at a rising edge
    do begin
      @(posedge i_clk);
      t++;
    end while (wreq !== 1'b0 && t < 20);
    if (wreq !== 1'b0) begin
      failures++;
      final_report();
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    be <= 4'hF;
  endtask

  // Read the done flags until a bit of m shows
  task automatic poll(input logic [31:0] m);
    int t;
    t = 0;
    do begin
      bus(1'b0, 8'h08, 32'h0);
      t++;
    end while ((q & m) == 32'h0 && t < 40);
    if (t >= 40) begin
      failures++;
      final_report();
    end
  endtask

  task automatic pulse(input int e);
    @(posedge i_clk);
    event_selector <= 30'h1 << e;
    @(posedge i_clk);
    event_selector <= '0;
  endtask

  task automatic put_cfg(input int b, input chan_cfg_s s);
    for (int i = 0; i < 8; i++) begin
      u_mem.mem[b+i] = s[63-8*i -: 8];
    end
  endtask

  function automatic int exp_cnt(input logic [2:0] v, input int l,
                                 input int m);
    int r;
    case (v)
      3'h1: r = m + 1;
      3'h2: r = m;
      3'h3: r = m + 2;
      3'h4: r = m + 3;
      default: return l;
    endcase
    return (m >= l) ? l : r;
  endfunction

  // Main sequence
  initial begin
    seed = 77;
    failures = 0;
    checks = 0;
    i_resetn = 1'b0;
    {rd, wr, slow, adr, wd, event_selector} = '0;
    be = 4'hF;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    // Reset values, unmapped place, lane-0 refusal
    foreach (k_list[j]) begin
      bus(1'b0, k_list[j], 32'h0);
      cmp(q, 32'h0);
    end
    @(posedge i_clk);
    be <= 4'h0;
    bus(1'b1, 8'h10, 32'h1);
    bus(1'b0, 8'h10, 32'h0);
    cmp(q, 32'h0);
    bus(1'b1, 8'h10, 32'h1);
    bus(1'b1, 8'h18, 32'h40);
    // Channel 1 block transfers over every count-source code
    for (int v = 0; v < 8; v++) begin
      c = '0;
      c.src = 16'h0100;
      c.dst = 16'h0200;
      c.count_source_selector = 3'(v);
      c.len = 13'(2 + ($random(seed) & 3));
      c.transfer_mode_selector = TM_BLOCK;
      c.sinc = INC_1;
      c.dinc = INC_1;
      c.completion_irq_permit = v[0];
      c.m8 = v[1];
      put_cfg(16'h40, c);
      for (int i = 0; i < 8; i++) begin
        u_mem.mem[256+i] = 8'($random(seed));
        u_mem.mem[512+i] = 8'hEE;
      end
      u_mem.mem[256] = u_mem.mem[256] & 8'h83;
      // A count of zero still moves one item, so the bench never sets one up
      if (u_mem.mem[256][6:0] == 7'h00) begin
        u_mem.mem[256][0] = 1'b1;
      end
      n = c.m8 ? u_mem.mem[256][6:0] : u_mem.mem[256];
      k = exp_cnt(c.count_source_selector, c.len, n);
      bus(1'b1, 8'h00, 32'h02);
      repeat (10) @(posedge i_clk);
      bus(1'b1, 8'h04, 32'h02);
      poll(32'h02);
      cmp(q, 32'h02);
      for (int i = 0; i < 8; i++) begin
        cmp(u_mem.mem[512+i], i < k ? u_mem.mem[256+i] : 8'hEE);
      end
      bus(1'b0, 8'h0C, 32'h0);
      cmp(q, 32'(v[0]));
      cmp(irq, v[0]);
      bus(1'b0, 8'h00, 32'h0);
      cmp(q, 32'h0);
      bus(1'b1, 8'h08, 32'h1F);
      bus(1'b1, 8'h0C, 32'h1);
    end
    // Channel 2 repeated single words on event 5, slow memory
    c = '0;
    c.src = 16'h0180;
    c.dst = 16'h0280;
    c.len = 13'h3;
    c.word = 1'b1;
    c.transfer_mode_selector = TM_RSINGLE;
    c.event_selector = 5'h05;
    c.sinc = INC_2;
    c.dinc = INC_2;
    put_cfg(16'h48, c);
    for (int i = 0; i < 6; i++) begin
      u_mem.mem[384+i] = 8'($random(seed));
      u_mem.mem[640+i] = 8'hEE;
    end
    pulse(5);
    bus(1'b1, 8'h00, 32'h04);
    pulse(5);
    repeat (10) @(posedge i_clk);
    slow <= 1'b1;
    for (int p = 0; p < 3; p++) begin
      pulse(5);
      repeat (20) @(posedge i_clk);
      bus(1'b0, 8'h08, 32'h0);
      cmp(q, p == 2 ? 32'h04 : 32'h0);
    end
    for (int i = 0; i < 6; i++) begin
      cmp(u_mem.mem[640+i], u_mem.mem[384+i]);
    end
    bus(1'b0, 8'h00, 32'h0);
    cmp(q, 32'h04);
    // Channel 3 repeated block, source walks down, destination fixed
    c = '0;
    c.src = 16'h01A1;
    c.dst = 16'h02A0;
    c.len = 13'h2;
    c.transfer_mode_selector = TM_RBLOCK;
    c.event_selector = 5'h07;
    c.sinc = DEC_1;
    c.prio = 2'h3;
    put_cfg(16'h50, c);
    u_mem.mem[416] = 8'($random(seed));
    u_mem.mem[417] = 8'($random(seed));
    bus(1'b1, 8'h00, 32'h08);
    repeat (30) @(posedge i_clk);
    pulse(7);
    repeat (30) @(posedge i_clk);
    cmp(u_mem.mem[672], u_mem.mem[416]);
    bus(1'b0, 8'h00, 32'h0);
    cmp(q, 32'h0C);
    bus(1'b1, 8'h00, 32'h8C);
    bus(1'b0, 8'h00, 32'h0);
    cmp(q, 32'h0);
    final_report();
  end
endmodule
